// >>> hdl/bate_consts.svh
`ifndef BATE_CONSTS_SVH
`define BATE_CONSTS_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define BATE_ADR_CMD 12'h000
`define BATE_ADR_STATUS 12'h004
`define BATE_ADR_CYCLES 12'h008
// region tags on address bits 11:7
`define BATE_RGN_RF 5'h02
`define BATE_RGN_IO 5'h04
// data memory occupies 0x400..0x7fc, tag on bits 11:10
`define BATE_RGN_DM 2'h1

// ****************************************
// command word fields
// ****************************************
`define BATE_CMD_OP 28:24
`define BATE_CMD_DST 20:16
`define BATE_CMD_SRC 12:8
`define BATE_CMD_IMM 7:0
`define BATE_CMD_BIT 2:0
`define BATE_CMD_DISP 5:0

// ****************************************
// status flag positions and reset values
// ****************************************
`define BATE_FLAG_C 0
`define BATE_FLAG_Z 1
`define BATE_FLAG_N 2
`define BATE_FLAG_V 3
`define BATE_FLAG_S 4
`define BATE_FLAG_H 5
`define BATE_FLAG_T 6
`define BATE_FLAG_I 7
`define BATE_STATUS_FLAGS_REGISTER_RST 8'h00
`define BATE_CMD_RST 32'h0000_0000

// ****************************************
// pointer pairs and timing
// ****************************************
`define BATE_PTR_FIRST 5'h1a
`define BATE_PTR_SECOND 5'h1c
`define BATE_CYC_LONG 4'h2
`define BATE_CYC_SHORT 4'h1

`endif

// >>> hdl/bate_core.sv
`timescale 1ns/100ps
`include "bate_consts.svh"
module bate_core #(
    parameter int DMEM_AW = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [11:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack
);

    // ****************************************
    // state
    // ****************************************
    logic [7:0] rf_mem [32];
    logic [7:0] io_mem [32];
    logic [7:0] dm_mem [2**DMEM_AW];
    logic [7:0] status_flags_register_reg;
    logic [7:0] status_flags_register_next;
    logic [31:0] cmd_reg;
    logic [15:0] addr_reg;
    logic [15:0] addr_next;
    logic [3:0] cnt_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    bate_pkg::bate_state_e state_reg;
    bate_pkg::bate_state_e state_next;

    // ****************************************
    // command decode
    // ****************************************
    wire bate_pkg::bate_op_e op = bate_pkg::bate_op_e'(cmd_reg[`BATE_CMD_OP]);
    wire [4:0] dst_idx = cmd_reg[`BATE_CMD_DST];
    wire [4:0] src_idx = cmd_reg[`BATE_CMD_SRC];
    wire [7:0] imm = cmd_reg[`BATE_CMD_IMM];
    wire [2:0] bit_sel = cmd_reg[`BATE_CMD_BIT];
    wire [7:0] d_val = rf_mem[dst_idx];
    wire [7:0] s_val = rf_mem[src_idx];
    wire [7:0] io_val = io_mem[src_idx];
    wire [15:0] ptr_x = {rf_mem[`BATE_PTR_FIRST + 5'h1],
                         rf_mem[`BATE_PTR_FIRST]};
    wire [15:0] ptr_y = {rf_mem[`BATE_PTR_SECOND + 5'h1],
                         rf_mem[`BATE_PTR_SECOND]};
    wire carry = status_flags_register_reg[`BATE_FLAG_C];
    wire idle = (state_reg == bate_pkg::st_idle);
    wire exec = (state_reg == bate_pkg::st_exec);
    wire second = (state_reg == bate_pkg::st_second);

    // ****************************************
    // bus decode
    // ****************************************
    wire bus_req = wb_cyc && wb_stb && !ack_reg && idle;
    wire bus_wr = bus_req && wb_we;
    wire hit_cmd = (wb_adr == `BATE_ADR_CMD);
    wire hit_status = (wb_adr == `BATE_ADR_STATUS);
    wire hit_cycles = (wb_adr == `BATE_ADR_CYCLES);
    wire hit_rf = (wb_adr[11:7] == `BATE_RGN_RF);
    wire hit_io = (wb_adr[11:7] == `BATE_RGN_IO);
    wire hit_dm = (wb_adr[11:10] == `BATE_RGN_DM);
    wire start = bus_wr && hit_cmd;
    wire [4:0] bus_widx = wb_adr[6:2];
    wire [DMEM_AW-1:0] bus_didx = wb_adr[DMEM_AW+1:2];
    wire [31:0] rd_word =
        hit_cmd ? cmd_reg :
        hit_status ? {23'h0, !idle, status_flags_register_reg} :
        hit_cycles ? {28'h0, cnt_reg} :
        hit_rf ? {24'h0, rf_mem[bus_widx]} :
        hit_io ? {24'h0, io_mem[bus_widx]} :
        hit_dm ? {24'h0, dm_mem[bus_didx]} : 32'h0000_0000;

    // flag update shared by every shift and rotate
    function automatic logic [7:0] shift_flags(input logic [7:0] sr,
                                               input logic [7:0] res,
                                               input logic c);
        logic [7:0] f;
        f = sr;
        f[`BATE_FLAG_C] = c;
        f[`BATE_FLAG_Z] = (res == 8'h00);
        f[`BATE_FLAG_N] = res[7];
        f[`BATE_FLAG_V] = res[7] ^ c;
        return f;
    endfunction

    // ****************************************
    // execution
    // ****************************************
    logic we_a;
    logic [4:0] wa_a;
    logic [7:0] wd_a;
    logic we_b;
    logic [4:0] wa_b;
    logic [7:0] wd_b;
    logic io_we;
    logic [4:0] io_wa;
    logic [7:0] io_wd;
    logic dm_we;
    logic long_op;
    logic [4:0] pbase;
    logic [15:0] pval;

    always_comb begin
        status_flags_register_next = status_flags_register_reg;
        addr_next = addr_reg;
        we_a = 1'b0;
        wa_a = dst_idx;
        wd_a = 8'h00;
        we_b = 1'b0;
        wa_b = {dst_idx[4:1], 1'b1};
        wd_b = 8'h00;
        io_we = 1'b0;
        io_wa = src_idx;
        io_wd = io_val;
        dm_we = 1'b0;
        long_op = 1'b0;
        pbase = `BATE_PTR_SECOND;
        pval = ptr_y;
        if (idle) begin
            // software access only while no instruction is running
            we_a = bus_wr && hit_rf && wb_sel[0];
            wa_a = bus_widx;
            wd_a = wb_dat_w[7:0];
            io_we = bus_wr && hit_io && wb_sel[0];
            io_wa = bus_widx;
            io_wd = wb_dat_w[7:0];
            dm_we = bus_wr && hit_dm && wb_sel[0];
            if (bus_wr && hit_status && wb_sel[0]) begin
                status_flags_register_next = wb_dat_w[7:0];
            end
        end else if (exec) begin
            unique case (op)
                bate_pkg::io_bit_set_op,
                bate_pkg::io_bit_clear_op: begin
                    long_op = 1'b1;
                end
                bate_pkg::logical_left_shift_op: begin
                    we_a = 1'b1;
                    wd_a = {d_val[6:0], 1'b0};
                    status_flags_register_next = shift_flags(status_flags_register_reg, wd_a, d_val[7]);
                end
                bate_pkg::logical_right_shift_op: begin
                    we_a = 1'b1;
                    wd_a = {1'b0, d_val[7:1]};
                    status_flags_register_next = shift_flags(status_flags_register_reg, wd_a, d_val[0]);
                end
                bate_pkg::left_rotate_carry_op: begin
                    we_a = 1'b1;
                    wd_a = {d_val[6:0], carry};
                    status_flags_register_next = shift_flags(status_flags_register_reg, wd_a, d_val[7]);
                end
                bate_pkg::right_rotate_carry_op: begin
                    we_a = 1'b1;
                    wd_a = {carry, d_val[7:1]};
                    status_flags_register_next = shift_flags(status_flags_register_reg, wd_a, d_val[0]);
                end
                bate_pkg::arith_right_shift_op: begin
                    we_a = 1'b1;
                    wd_a = {d_val[7], d_val[7:1]};
                    status_flags_register_next = shift_flags(status_flags_register_reg, wd_a, d_val[0]);
                end
                bate_pkg::nibble_swap_op: begin
                    we_a = 1'b1;
                    wd_a = {d_val[3:0], d_val[7:4]};
                end
                bate_pkg::flag_set_op: begin
                    status_flags_register_next[bit_sel] = 1'b1;
                end
                bate_pkg::flag_clear_op: begin
                    status_flags_register_next[bit_sel] = 1'b0;
                end
                bate_pkg::bit_to_transfer_flag_op: begin
                    status_flags_register_next[`BATE_FLAG_T] = s_val[bit_sel];
                end
                bate_pkg::transfer_flag_to_bit_op: begin
                    we_a = 1'b1;
                    wd_a = d_val;
                    wd_a[bit_sel] = status_flags_register_reg[`BATE_FLAG_T];
                end
                bate_pkg::reg_copy_op: begin
                    we_a = 1'b1;
                    wd_a = s_val;
                end
                bate_pkg::reg_pair_copy_op: begin
                    // odd indices are forced even: the pair always aligns
                    we_a = 1'b1;
                    wa_a = {dst_idx[4:1], 1'b0};
                    wd_a = rf_mem[{src_idx[4:1], 1'b0}];
                    we_b = 1'b1;
                    wd_b = rf_mem[{src_idx[4:1], 1'b1}];
                end
                bate_pkg::immediate_load_op: begin
                    we_a = 1'b1;
                    wd_a = imm;
                end
                bate_pkg::first_ptr_load_op,
                bate_pkg::second_ptr_load_op: begin
                    long_op = 1'b1;
                    addr_next = (op == bate_pkg::first_ptr_load_op) ?
                                ptr_x : ptr_y;
                end
                bate_pkg::first_ptr_inc_load_op,
                bate_pkg::second_ptr_inc_load_op: begin
                    long_op = 1'b1;
                    if (op == bate_pkg::first_ptr_inc_load_op) begin
                        pbase = `BATE_PTR_FIRST;
                        pval = ptr_x;
                    end
                    addr_next = pval;
                    {wd_b, wd_a} = pval + 16'h0001;
                    we_a = 1'b1;
                    wa_a = pbase;
                    we_b = 1'b1;
                    wa_b = pbase + 5'h1;
                end
                bate_pkg::first_ptr_dec_load_op,
                bate_pkg::second_ptr_dec_load_op: begin
                    long_op = 1'b1;
                    if (op == bate_pkg::first_ptr_dec_load_op) begin
                        pbase = `BATE_PTR_FIRST;
                        pval = ptr_x;
                    end
                    // the read uses the already decremented address
                    addr_next = pval - 16'h0001;
                    {wd_b, wd_a} = addr_next;
                    we_a = 1'b1;
                    wa_a = pbase;
                    we_b = 1'b1;
                    wa_b = pbase + 5'h1;
                end
                bate_pkg::displacement_load_op: begin
                    long_op = 1'b1;
                    addr_next = ptr_y + {10'h000, imm[`BATE_CMD_DISP]};
                end
                default: begin
                    long_op = 1'b0;
                end
            endcase
        end else begin
            unique case (op)
                bate_pkg::io_bit_set_op: begin
                    io_we = 1'b1;
                    io_wd[bit_sel] = 1'b1;
                end
                bate_pkg::io_bit_clear_op: begin
                    io_we = 1'b1;
                    io_wd[bit_sel] = 1'b0;
                end
                default: begin
                    // second cycle of every load writes the memory byte
                    we_a = 1'b1;
                    wd_a = dm_mem[addr_reg[DMEM_AW-1:0]];
                end
            endcase
        end
    end

    always_comb begin
        unique case (state_reg)
            bate_pkg::st_idle: state_next = start ? bate_pkg::st_exec :
                                                    bate_pkg::st_idle;
            bate_pkg::st_exec: state_next = long_op ? bate_pkg::st_second :
                                                      bate_pkg::st_idle;
            bate_pkg::st_second: state_next = bate_pkg::st_idle;
            default: state_next = bate_pkg::st_idle;
        endcase
    end

    // ****************************************
    // storage
    // ****************************************
    always_ff @(posedge clk) begin
        if (we_a) begin
            rf_mem[wa_a] <= wd_a;
        end
        if (we_b) begin
            rf_mem[wa_b] <= wd_b;
        end
        if (io_we) begin
            io_mem[io_wa] <= io_wd;
        end
        if (dm_we) begin
            dm_mem[bus_didx] <= wb_dat_w[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= bate_pkg::st_idle;
            status_flags_register_reg <= `BATE_STATUS_FLAGS_REGISTER_RST;
            addr_reg <= 16'h0000;
            cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            status_flags_register_reg <= status_flags_register_next;
            addr_reg <= addr_next;
            cnt_reg <= start ? 4'h0 : (idle ? cnt_reg : cnt_reg + 4'h1);
        end
    end

    // command bytes honour the lane selects; any command write starts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_reg <= `BATE_CMD_RST;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (start && wb_sel[i]) begin
                    cmd_reg[i*8 +: 8] <= wb_dat_w[i*8 +: 8];
                end
            end
        end
    end

    // ack waits while an instruction runs: that is the bus back-pressure
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req;
            if (bus_req && !wb_we) begin
                rdata_reg <= rd_word;
            end
        end
    end

    assign wb_ack = ack_reg;
    assign wb_dat_r = rdata_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire is_flag_op = (op == bate_pkg::flag_set_op) ||
                      (op == bate_pkg::flag_clear_op);
    wire is_set = (op == bate_pkg::flag_set_op);
    wire is_ptr_dec = (op == bate_pkg::first_ptr_dec_load_op);
    wire [2:0] cnt_low = cnt_reg[2:0];

    sequence s_two_cycles;
        second ##1 (idle && cnt_reg == `BATE_CYC_LONG);
    endsequence
    sequence s_one_cycle;
        idle && cnt_reg == `BATE_CYC_SHORT;
    endsequence

    a_io_set_bit: assert property (
        exec && op == bate_pkg::io_bit_set_op |=> s_two_cycles and
        (##1 io_mem[src_idx][bit_sel] && $stable(status_flags_register_reg)))
        else $error("io bit set failed");
    a_io_clear_bit: assert property (
        exec && op == bate_pkg::io_bit_clear_op |=> s_two_cycles and
        (##1 !io_mem[src_idx][bit_sel] && $stable(status_flags_register_reg)))
        else $error("io bit clear failed");
    a_shift_left: assert property (
        exec && op == bate_pkg::logical_left_shift_op |=> s_one_cycle and
        (rf_mem[dst_idx] == 8'($past(d_val) << 1) &&
        status_flags_register_reg[`BATE_FLAG_C] == $past(d_val[7])))
        else $error("left shift wrong");
    a_shift_right: assert property (
        exec && op == bate_pkg::logical_right_shift_op |=> s_one_cycle and
        (rf_mem[dst_idx] == ($past(d_val) >> 1) &&
        status_flags_register_reg[`BATE_FLAG_Z] == (rf_mem[dst_idx] == 8'h00)))
        else $error("right shift wrong");
    a_rotate_left: assert property (
        exec && op == bate_pkg::left_rotate_carry_op |=>
        rf_mem[dst_idx][0] == $past(carry) &&
        status_flags_register_reg[`BATE_FLAG_C] == $past(d_val[7]))
        else $error("left rotate wrong");
    a_rotate_right: assert property (
        exec && op == bate_pkg::right_rotate_carry_op |=>
        rf_mem[dst_idx][7] == $past(carry) &&
        status_flags_register_reg[`BATE_FLAG_C] == $past(d_val[0]))
        else $error("right rotate wrong");
    a_arith_shift: assert property (
        exec && op == bate_pkg::arith_right_shift_op |=>
        rf_mem[dst_idx][7:6] == {2{$past(d_val[7])}} &&
        (status_flags_register_reg[`BATE_FLAG_N] ^ status_flags_register_reg[`BATE_FLAG_C]) ==
        status_flags_register_reg[`BATE_FLAG_V])
        else $error("arithmetic shift wrong");
    a_bit_to_t: assert property (
        exec && op == bate_pkg::bit_to_transfer_flag_op |=> s_one_cycle and
        (status_flags_register_reg[`BATE_FLAG_T] == s_val[bit_sel] &&
        (status_flags_register_reg & 8'hbf) == ($past(status_flags_register_reg) & 8'hbf)))
        else $error("bit store wrong");
    a_t_to_bit: assert property (
        exec && op == bate_pkg::transfer_flag_to_bit_op |=>
        rf_mem[dst_idx][bit_sel] == status_flags_register_reg[`BATE_FLAG_T] &&
        $stable(status_flags_register_reg))
        else $error("bit load wrong");
    a_irq_flag: assert property (
        exec && is_flag_op && bit_sel == 3'h7 |=>
        status_flags_register_reg[7] == $past(is_set) &&
        status_flags_register_reg[6:0] == $past(status_flags_register_reg[6:0]))
        else $error("interrupt flag wrong");
    a_ovf_flag: assert property (
        exec && is_flag_op && bit_sel == 3'h3 |=>
        (status_flags_register_reg[3] == $past(is_set)) and s_one_cycle)
        else $error("overflow flag wrong");
    a_sign_flag: assert property (
        exec && is_flag_op && bit_sel == 3'h4 |=>
        status_flags_register_reg[4] == $past(is_set) && status_flags_register_reg[3] == $past(status_flags_register_reg[3]))
        else $error("sign flag wrong");
    a_half_flag: assert property (
        exec && is_flag_op && bit_sel == 3'h5 |=>
        status_flags_register_reg[5] == $past(is_set) && status_flags_register_reg[4] == $past(status_flags_register_reg[4]))
        else $error("half carry flag wrong");
    a_copy_reg: assert property (
        exec && op == bate_pkg::reg_copy_op |=> s_one_cycle and
        (rf_mem[dst_idx] == $past(s_val) && $stable(status_flags_register_reg)))
        else $error("register copy wrong");
    a_first_dec: assert property (
        exec && is_ptr_dec |=> ptr_x == $past(ptr_x) - 16'h0001
        ##1 (rf_mem[dst_idx] == dm_mem[$past(addr_reg[DMEM_AW-1:0])]))
        else $error("pre-decrement load wrong");
    a_load_time: assert property (
        exec && op >= bate_pkg::first_ptr_load_op &&
        op <= bate_pkg::displacement_load_op |=> s_two_cycles)
        else $error("load not two cycles");
    a_swap_nib: assert property (
        exec && op == bate_pkg::nibble_swap_op |=>
        rf_mem[dst_idx] == {$past(d_val[3:0]), $past(d_val[7:4])})
        else $error("nibble swap wrong");
    a_imm_load: assert property (
        exec && op == bate_pkg::immediate_load_op |=> s_one_cycle and
        (rf_mem[dst_idx] == imm))
        else $error("immediate load wrong");
    a_low_flags: assert property (
        exec && is_flag_op && (bit_sel < 3'h3 || bit_sel == 3'h6) |=>
        status_flags_register_reg[bit_sel] == $past(is_set) && cnt_low == 3'h1)
        else $error("low flag wrong");

endmodule // bate_core

// >>> hdl/bate_pkg.sv
package bate_pkg;

    typedef enum logic [4:0] {
        io_bit_set_op,
        io_bit_clear_op,
        logical_left_shift_op,
        logical_right_shift_op,
        left_rotate_carry_op,
        right_rotate_carry_op,
        arith_right_shift_op,
        nibble_swap_op,
        flag_set_op,
        flag_clear_op,
        bit_to_transfer_flag_op,
        transfer_flag_to_bit_op,
        reg_copy_op,
        reg_pair_copy_op,
        immediate_load_op,
        first_ptr_load_op,
        first_ptr_inc_load_op,
        first_ptr_dec_load_op,
        second_ptr_load_op,
        second_ptr_inc_load_op,
        second_ptr_dec_load_op,
        displacement_load_op,
        idle_op
    } bate_op_e;

    typedef enum logic [1:0] {
        st_idle,
        st_exec,
        st_second
    } bate_state_e;

endpackage

// >>> test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic clk, rst, cyc, stb, we, ack;
    logic [11:0] adr;
    logic [31:0] dw, dr, q;
    integer seed = 23916;
    int n_errors = 0;
    int cmp_count = 0;

    bate_core i_bate_core (.clk(clk), .rst(rst), .wb_cyc(cyc), .wb_stb(stb),
        .wb_we(we), .wb_adr(adr), .wb_sel(4'hf), .wb_dat_w(dw),
        .wb_dat_r(dr), .wb_ack(ack));

    // ****************************************
    // expectations
    // ****************************************
    // returns {flags, destination byte}; shifts touch V N Z C only
    function automatic logic [15:0] model(input logic [4:0] op,
        input logic [7:0] rd, rr, imm, f);
        logic [7:0] r, nf;
        logic c;
        r = rd;
        nf = f;
        c = f[0];
        case (op)
            5'h02: {c, r} = {rd, 1'b0};
            5'h03: {r, c} = {1'b0, rd};
            5'h04: {c, r} = {rd, f[0]};
            5'h05: {r, c} = {f[0], rd};
            5'h06: {r, c} = {rd[7], rd};
            5'h07: r = {rd[3:0], rd[7:4]};
            5'h08: nf[imm[2:0]] = 1'b1;
            5'h09: nf[imm[2:0]] = 1'b0;
            5'h0a: nf[6] = rr[imm[2:0]];
            5'h0b: r[imm[2:0]] = f[6];
            5'h0c, 5'h0d: r = rr;
            5'h0e: r = imm;
            default: ;
        endcase
        if (op >= 5'h02 && op <= 5'h06) begin
            nf[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
        end
        return {nf, r};
    endfunction

    // ****************************************
    // bus and compare
    // ****************************************
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) n_errors++;
        q = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic chk(input string nm, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tail(input logic [7:0] f, cy);
        bus(1'b0, 12'h004, 32'h0);
        chk("flags", f, q[7:0]);
        bus(1'b0, 12'h008, 32'h0);
        chk("cycles", cy, q[7:0]);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // the command write is followed at once by reads, but each access ends with an idle cycle,
    // so even a two-cycle instruction finishes first and the bus stall is never exercised
    task automatic alu(input logic [4:0] op, d, s, input logic [7:0] imm);
        logic [7:0] a, b, f;
        logic [15:0] e;
        a = 8'($random(seed));
        b = (s == d) ? a : 8'($random(seed));
        f = 8'($random(seed));
        bus(1'b1, 12'h100 + {d, 2'b00}, {24'h0, a});
        bus(1'b1, 12'h100 + {s, 2'b00}, {24'h0, b});
        if (op == 5'h0d) bus(1'b1, 12'h104 + {s, 2'b00}, {24'h0, ~b});
        bus(1'b1, 12'h004, {24'h0, f});
        bus(1'b1, 12'h000, {3'h0, op, 3'h0, d, 3'h0, s, imm});
        e = model(op, a, b, imm, f);
        bus(1'b0, 12'h100 + {d, 2'b00}, 32'h0);
        chk("dest", e[7:0], q[7:0]);
        if (op == 5'h0d) begin
            bus(1'b0, 12'h104 + {d, 2'b00}, 32'h0);
            chk("dest high", ~b, q[7:0]);
        end
        tail(e[15:8], 8'h01);
    endtask

    task automatic io(input logic set, input logic [4:0] p,
        input logic [2:0] b);
        logic [7:0] v, f;
        v = 8'($random(seed));
        f = 8'($random(seed));
        bus(1'b1, 12'h200 + {p, 2'b00}, {24'h0, v});
        bus(1'b1, 12'h004, {24'h0, f});
        bus(1'b1, 12'h000, {7'h0, ~set, 11'h0, p, 5'h0, b});
        v[b] = set;
        bus(1'b0, 12'h200 + {p, 2'b00}, 32'h0);
        chk("io byte", v, q[7:0]);
        tail(f, 8'h02);
    endtask

    task automatic ld(input logic [4:0] op);
        logic [7:0] p, k, v, f, a;
        logic [4:0] d, pb;
        p = 8'h40 + 8'($unsigned($random(seed)) % 128);
        k = 8'($unsigned($random(seed)) % 64);
        v = 8'($random(seed));
        f = 8'($random(seed));
        d = 5'($unsigned($random(seed)) % 26);
        pb = (op < 5'd18) ? 5'd26 : 5'd28;
        a = (op == 5'd17 || op == 5'd20) ? p - 8'h01 : p;
        if (op == 5'd21) a = p + k;
        bus(1'b1, 12'h100 + {pb, 2'b00}, {24'h0, p});
        bus(1'b1, 12'h104 + {pb, 2'b00}, 32'h0);
        bus(1'b1, 12'h400 + {a, 2'b00}, {24'h0, v});
        bus(1'b1, 12'h004, {24'h0, f});
        bus(1'b1, 12'h000, {3'h0, op, 3'h0, d, 8'h00, k});
        bus(1'b0, 12'h100 + {d, 2'b00}, 32'h0);
        chk("load data", v, q[7:0]);
        if (op == 5'd16 || op == 5'd19) p = p + 8'h01;
        if (op == 5'd17 || op == 5'd20) p = p - 8'h01;
        bus(1'b0, 12'h100 + {pb, 2'b00}, 32'h0);
        chk("pointer low", p, q[7:0]);
        bus(1'b0, 12'h104 + {pb, 2'b00}, 32'h0);
        chk("pointer high", 8'h00, q[7:0]);
        tail(f, 8'h02);
    endtask

    task automatic test_done();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // a run needs about 2400 cycles; twenty times that means a hang
    initial begin
        repeat (50000) @(posedge clk);
        n_errors++;
        test_done();
    end

    initial begin
        logic [4:0] op, d, s;
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 12'h000;
        dw = 32'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, 12'h004, 32'h0);
        chk("flags after reset", 8'h00, q[7:0]);
        for (int i = 0; i < 8; i++) begin
            alu(5'h08, 5'd1, 5'd2, 8'(i));
            alu(5'h09, 5'd1, 5'd2, 8'(i));
            io(1'b1, 5'(i * 3), 3'(i));
            io(1'b0, 5'(i * 5), 3'(i));
        end
        alu(5'h0d, 5'd4, 5'd10, 8'h00);
        for (int i = 0; i < 60; i++) begin
            op = 5'h02 + 5'($unsigned($random(seed)) % 13);
            d = 5'($random(seed));
            s = 5'($random(seed));
            if (op == 5'h0d) s = d ^ 5'h08;
            alu(op, d & {4'hf, op != 5'h0d}, s & {4'hf, op != 5'h0d}, 8'($random(seed)));
        end
        for (int i = 0; i < 14; i++) begin
            ld(5'd15 + 5'(i % 7));
        end
        test_done();
    end
endmodule // tb_top
